// ---- rtl/tuss_pkg.sv ----
package tuss_pkg;

	localparam int unsigned IDX_W = 16;
	localparam int unsigned DATA_W = 16;

	localparam logic [IDX_W-1:0] IDX_PASSWORD = 16'h0002;
	localparam logic [IDX_W-1:0] IDX_GROUP_SEL = 16'h0003;
	localparam logic [IDX_W-1:0] IDX_RATED_CURRENT = 16'h0004;
	localparam logic [IDX_W-1:0] IDX_SIZE_CODE = 16'h0005;
	localparam logic [IDX_W-1:0] IDX_CAP_ONE = 16'h0006;
	localparam logic [IDX_W-1:0] IDX_CAP_TWO = 16'h0007;
	localparam logic [IDX_W-1:0] IDX_THERMAL = 16'h0008;

	localparam logic [DATA_W-1:0] PASSWORD_RST = 16'h0000;
	localparam logic [DATA_W-1:0] GROUP_SEL_RST = 16'h0000;
	localparam logic THERMAL_RST = 1'b1;

	localparam int unsigned RATED_CURRENT_W = 13;
	localparam int unsigned SIZE_CODE_W = 3;
	localparam logic [DATA_W-1:0] SIZE_CODE_MASK = 16'h0007;
	localparam logic [DATA_W-1:0] RATED_CURRENT_MASK = 16'h1fff;
	localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

	// First capability word bit positions.
	localparam int unsigned CAP1_OVERLOAD = 0;
	localparam int unsigned CAP1_SHORT_DELAY = 1;
	localparam int unsigned CAP1_INSTANT = 2;
	localparam int unsigned CAP1_GROUND_FAULT = 3;
	localparam int unsigned CAP1_MAINT_MODE = 4;
	localparam int unsigned CAP1_OVERRIDE = 5;
	localparam int unsigned CAP1_MOTOR = 7;
	localparam int unsigned CAP1_FOUR_POLE = 8;
	localparam int unsigned CAP1_HEAT_MEM = 9;
	localparam int unsigned CAP1_VOLT_METER = 12;
	localparam int unsigned CAP1_EXTENDED = 13;

	// Second capability word bit positions.
	localparam int unsigned CAP2_SERIAL_BUS = 0;
	localparam int unsigned CAP2_ACCESSORY = 1;
	localparam int unsigned CAP2_IO_EXP = 2;
	localparam int unsigned CAP2_RELAY = 3;
	localparam int unsigned CAP2_ZONE_SEL = 4;
	localparam int unsigned CAP2_DISPLAY = 5;

	localparam int unsigned THERMAL_BIT = 0;

	typedef struct packed {
		logic has_overload_prot;
		logic has_short_delay_prot;
		logic has_instant_prot;
		logic has_ground_fault_prot;
		logic has_maintenance_mode;
		logic has_override_release;
		logic has_motor_prot;
		logic four_pole_flag;
		logic has_heat_memory;
		logic has_voltage_meter;
		logic extended_variant;
		logic has_serial_fieldbus;
		logic has_accessory_link;
		logic has_io_expansion;
		logic has_relay_option;
		logic has_zone_selectivity;
		logic has_local_display;
	} tuss_fit_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [IDX_W-1:0] index;
		logic [DATA_W-1:0] wdata;
	} tuss_req_t;

	typedef struct packed {
		logic valid;
		logic error;
		logic [DATA_W-1:0] rdata;
	} tuss_rsp_t;

endpackage : tuss_pkg

// ---- rtl/tuss_regs.sv ----
module tuss_regs
	import tuss_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tuss_req_t req_i,
	input wire tuss_fit_t fit_i,
	input wire logic [SIZE_CODE_W-1:0] size_code_i,
	input wire logic [RATED_CURRENT_W-1:0] rated_current_i,
	output tuss_rsp_t rsp_o,
	output logic [DATA_W-1:0] access_password_o,
	output logic [DATA_W-1:0] protection_group_select_o,
	output logic thermal_memory_enable_o
);

	////////////////////////////////////////////////////////////////
	// Identification inputs are straps from outside; two flops each.

	tuss_fit_t fit_s1_q;
	tuss_fit_t fit_s2_q;
	logic [SIZE_CODE_W-1:0] size_s1_q;
	logic [SIZE_CODE_W-1:0] size_s2_q;
	logic [RATED_CURRENT_W-1:0] cur_s1_q;
	logic [RATED_CURRENT_W-1:0] cur_s2_q;

	// Straps are meant to be fixed at power-up; a change shows in the words only after two edges.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fit_s1_q <= '0;
			fit_s2_q <= '0;
		end else begin
			fit_s1_q <= fit_i;
			fit_s2_q <= fit_s1_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			size_s1_q <= '0;
			size_s2_q <= '0;
		end else begin
			size_s1_q <= size_code_i;
			size_s2_q <= size_s1_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_s1_q <= '0;
			cur_s2_q <= '0;
		end else begin
			cur_s1_q <= rated_current_i;
			cur_s2_q <= cur_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read-only word assembly.

	logic [DATA_W-1:0] cap_one;
	logic [DATA_W-1:0] cap_two;
	logic [DATA_W-1:0] size_word;
	logic [DATA_W-1:0] cur_word;

	always_comb begin
		cap_one = ZERO_WORD;
		cap_one[CAP1_OVERLOAD] = fit_s2_q.has_overload_prot;
		cap_one[CAP1_SHORT_DELAY] = fit_s2_q.has_short_delay_prot;
		cap_one[CAP1_INSTANT] = fit_s2_q.has_instant_prot;
		cap_one[CAP1_GROUND_FAULT] = fit_s2_q.has_ground_fault_prot;
		cap_one[CAP1_MAINT_MODE] = fit_s2_q.has_maintenance_mode;
		cap_one[CAP1_OVERRIDE] = fit_s2_q.has_override_release;
		cap_one[CAP1_MOTOR] = fit_s2_q.has_motor_prot;
		cap_one[CAP1_FOUR_POLE] = fit_s2_q.four_pole_flag;
		cap_one[CAP1_HEAT_MEM] = fit_s2_q.has_heat_memory;
		cap_one[CAP1_VOLT_METER] = fit_s2_q.has_voltage_meter;
		cap_one[CAP1_EXTENDED] = fit_s2_q.extended_variant;
	end

	always_comb begin
		cap_two = ZERO_WORD;
		cap_two[CAP2_SERIAL_BUS] = fit_s2_q.has_serial_fieldbus;
		cap_two[CAP2_ACCESSORY] = fit_s2_q.has_accessory_link;
		cap_two[CAP2_IO_EXP] = fit_s2_q.has_io_expansion;
		cap_two[CAP2_RELAY] = fit_s2_q.has_relay_option;
		cap_two[CAP2_ZONE_SEL] = fit_s2_q.has_zone_selectivity;
		cap_two[CAP2_DISPLAY] = fit_s2_q.has_local_display;
	end

	// The masks hold the numeric words to their field widths even if the strap widths are changed.
	always_comb begin
		size_word = {{(DATA_W-SIZE_CODE_W){1'b0}}, size_s2_q} & SIZE_CODE_MASK;
		cur_word = {{(DATA_W-RATED_CURRENT_W){1'b0}}, cur_s2_q} & RATED_CURRENT_MASK;
	end

	////////////////////////////////////////////////////////////////
	// Request decode: one select per mapped index.

	logic rd_req;
	logic wr_req;
	logic sel_password;
	logic sel_group;
	logic sel_rated;
	logic sel_size;
	logic sel_cap_one;
	logic sel_cap_two;
	logic sel_thermal;
	logic ro_index;
	logic known_index;
	logic refuse_wr;
	logic refuse_rd;

	always_comb begin
		rd_req = req_i.rd;
		wr_req = req_i.wr;
		sel_password = (req_i.index == IDX_PASSWORD);
		sel_group = (req_i.index == IDX_GROUP_SEL);
		sel_rated = (req_i.index == IDX_RATED_CURRENT);
		sel_size = (req_i.index == IDX_SIZE_CODE);
		sel_cap_one = (req_i.index == IDX_CAP_ONE);
		sel_cap_two = (req_i.index == IDX_CAP_TWO);
		sel_thermal = (req_i.index == IDX_THERMAL);
	end

	// Identification words are never stored here, so refusing the write only sets the error flag in the response.
	always_comb begin
		ro_index = sel_rated || sel_size || sel_cap_one || sel_cap_two;
		known_index = ro_index || sel_password || sel_group || sel_thermal;
		refuse_wr = ro_index || !known_index;
		refuse_rd = !known_index || sel_password;
	end

	////////////////////////////////////////////////////////////////
	// Writable settings.

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			access_password_o <= PASSWORD_RST;
		end else if (wr_req && sel_password) begin
			access_password_o <= req_i.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			protection_group_select_o <= GROUP_SEL_RST;
		end else if (wr_req && sel_group) begin
			protection_group_select_o <= req_i.wdata;
		end
	end

	// Defaults to on: a trip unit that forgets its heat history after reset is the unsafe choice.
	// Only bit 0 of the written word is kept; the other bits are dropped.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thermal_memory_enable_o <= THERMAL_RST;
		end else if (wr_req && sel_thermal) begin
			thermal_memory_enable_o <= req_i.wdata[THERMAL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// Response: one cycle after each request, read data or refusal.

	tuss_rsp_t rsp_d;
	logic [DATA_W-1:0] rdata_sel;

	// The password and unmapped indices read as zero.
	always_comb begin
		rdata_sel = ZERO_WORD;
		if (sel_group) begin
			rdata_sel = protection_group_select_o;
		end
		if (sel_rated) begin
			rdata_sel = cur_word;
		end
		if (sel_size) begin
			rdata_sel = size_word;
		end
		if (sel_cap_one) begin
			rdata_sel = cap_one;
		end
		if (sel_cap_two) begin
			rdata_sel = cap_two;
		end
		if (sel_thermal) begin
			rdata_sel = {{(DATA_W-1){1'b0}}, thermal_memory_enable_o};
		end
	end

	// A write answers with zero data; only the error flag tells the master that it was refused.
	always_comb begin
		rsp_d = '0;
		rsp_d.valid = rd_req || wr_req;
		if (wr_req) begin
			rsp_d.error = refuse_wr;
		end else if (rd_req) begin
			rsp_d.error = refuse_rd;
			rsp_d.rdata = rdata_sel;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_o <= '0;
		end else begin
			rsp_o <= rsp_d;
		end
	end

endmodule : tuss_regs

// ---- dv/tuss_checker.sv ----
module tuss_checker
	import tuss_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tuss_req_t req_i,
	input wire tuss_fit_t fit_i,
	input wire logic [SIZE_CODE_W-1:0] size_code_i,
	input wire logic [RATED_CURRENT_W-1:0] rated_current_i,
	input wire tuss_rsp_t rsp_o,
	input wire logic [DATA_W-1:0] access_password_o,
	input wire logic [DATA_W-1:0] protection_group_select_o,
	input wire logic thermal_memory_enable_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	function automatic logic hit(tuss_req_t q, logic w, logic [IDX_W-1:0] i);
		return (w ? q.wr : q.rd) && q.index == i;
	endfunction : hit
	pw_hidden_a: assert property (hit(req_i, 0, IDX_PASSWORD) |=> rsp_o.error && rsp_o.rdata == ZERO_WORD)
		else $error("password read not refused");
	pw_store_a: assert property (hit(req_i, 1, IDX_PASSWORD) |=> access_password_o == $past(req_i.wdata))
		else $error("password not stored");
	size_read_a: assert property (hit(req_i, 0, IDX_SIZE_CODE) |=> rsp_o.rdata == {13'h0, size_code_i})
		else $error("size code wrong");
	cap_prot_a: assert property (hit(req_i, 0, IDX_CAP_ONE) |=> rsp_o.rdata[3:0] == {fit_i[13], fit_i[14], fit_i[15], fit_i[16]})
		else $error("protection bits wrong");
	cap_option_a: assert property (hit(req_i, 0, IDX_CAP_ONE) |=> rsp_o.rdata[8:4] == {fit_i[9], fit_i[10], 1'b0, fit_i[11], fit_i[12]})
		else $error("option bits wrong");
	cap_upper_a: assert property (hit(req_i, 0, IDX_CAP_ONE) |=> rsp_o.rdata[15:9] == {2'b0, fit_i[6], fit_i[7], 2'b0, fit_i[8]})
		else $error("upper bits wrong");
	cap_two_a: assert property (hit(req_i, 0, IDX_CAP_TWO) |=> rsp_o.rdata == {10'h0, fit_i[0], fit_i[1], fit_i[2], fit_i[3], fit_i[4], fit_i[5]})
		else $error("second word wrong");
	heat_set_a: assert property (hit(req_i, 1, IDX_THERMAL) |=> thermal_memory_enable_o == $past(req_i.wdata[0]))
		else $error("thermal enable not written");
	heat_read_a: assert property (hit(req_i, 0, IDX_THERMAL) |=> rsp_o.rdata == {15'h0, thermal_memory_enable_o})
		else $error("thermal readback wrong");
	ro_write_a: assert property (req_i.wr && req_i.index inside {[IDX_RATED_CURRENT:IDX_CAP_TWO]} |=> rsp_o.valid && rsp_o.error)
		else $error("read-only write accepted");
endmodule : tuss_checker
bind tuss_regs tuss_checker tuss_checker_inst(.clk_i, .rst_i, .req_i, .fit_i, .size_code_i, .rated_current_i, .rsp_o,
	.access_password_o, .protection_group_select_o, .thermal_memory_enable_o);

// ---- dv/tuss_master.sv ----
module tuss_master
	import tuss_pkg::*;
(
	input wire logic clk_i,
	input wire tuss_rsp_t rsp_i,
	output tuss_req_t req_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial req_o = '0;
	// Idle fields carry inverted values so a design that ignores the strobes is caught.
	task automatic xfer(input logic w, input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d, output tuss_rsp_t r);
		@(negedge clk_i);
		req_o = '{wr: w, rd: !w, index: i, wdata: d};
		@(negedge clk_i);
		r = rsp_i;
		req_o = '{wr: 1'b0, rd: 1'b0, index: ~i, wdata: ~d};
	endtask : xfer
endmodule : tuss_master

// ---- dv/tb_top.sv ----
module tb_top;
	import tuss_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	// The inverse pattern is run as well, so every strap bit is seen at both levels.
	localparam tuss_fit_t FIT = 17'h16b65;
	tuss_fit_t fit = FIT;
	logic [2:0] size = 3'h5;
	logic [12:0] amps = 13'h1abc;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	int failures = 0;
	int total_checks = 0;
	int cyc = 0;
	tuss_req_t req_i;
	tuss_rsp_t rsp_o;
	tuss_rsp_t r;
	logic [15:0] pw;
	logic [15:0] grp;
	logic te;
	logic [15:0] ident [4] = '{16'h1abc, 16'h0005, 16'h232d, 16'h0029};
	always #12.5 clk_i = ~clk_i;
	tuss_regs tuss_regs_inst(.clk_i, .rst_i, .req_i, .fit_i(fit), .size_code_i(size), .rated_current_i(amps),
		.rsp_o, .access_password_o(pw), .protection_group_select_o(grp), .thermal_memory_enable_o(te));
	tuss_master tuss_master_inst(.clk_i, .rsp_i(rsp_o), .req_o(req_i));
	////////////////////////////////////////
	task chk(input logic [17:0] g, input logic [17:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task xf(input logic w, input logic [15:0] i, input logic [15:0] d);
		tuss_master_inst.xfer(w, i, d, r);
	endtask : xf
	task test_password;
		chk(pw, 16'h0000);
		xf(1'b1, IDX_PASSWORD, 16'hc3a5);
		chk({r.valid, r.error}, 2'b10);
		chk(pw, 16'hc3a5);
		xf(1'b0, IDX_PASSWORD, 16'h0);
		chk({r.valid, r.error, r.rdata}, 18'h30000);
		$display("password test done");
	endtask : test_password
	task test_ident;
		for (int i = 0; i < 4; i++) begin
			xf(1'b0, 16'(IDX_RATED_CURRENT + i), 16'h0);
			chk({r.valid, r.error, r.rdata}, {2'b10, ident[i]});
			xf(1'b1, 16'(IDX_RATED_CURRENT + i), ~ident[i]);
			chk({r.valid, r.error}, 2'b11);
			xf(1'b0, 16'(IDX_RATED_CURRENT + i), 16'h0);
			chk(r.rdata, ident[i]);
		end
		$display("identification test done");
	endtask : test_ident
	task test_settings;
		chk(te, 1'b1);
		xf(1'b1, IDX_THERMAL, 16'hfffe);
		chk({r.valid, r.error}, 2'b10);
		chk(te, 1'b0);
		xf(1'b0, IDX_THERMAL, 16'h0);
		chk({r.valid, r.error, r.rdata}, 18'h20000);
		xf(1'b1, IDX_THERMAL, 16'h0001);
		chk(te, 1'b1);
		xf(1'b0, IDX_THERMAL, 16'h0);
		chk(r.rdata, 16'h0001);
		xf(1'b1, IDX_GROUP_SEL, 16'h5a3c);
		chk({r.valid, r.error}, 2'b10);
		xf(1'b0, IDX_GROUP_SEL, 16'h0);
		chk(r.rdata, 16'h5a3c);
		chk(grp, 16'h5a3c);
		$display("settings test done");
	endtask : test_settings
	task test_unmapped;
		xf(1'b0, 16'h0009, 16'h0);
		chk({r.valid, r.error, r.rdata}, 18'h30000);
		xf(1'b1, 16'h0001, 16'hffff);
		chk({r.valid, r.error}, 2'b11);
		chk(grp, 16'h5a3c);
		$display("unmapped test done");
	endtask : test_unmapped
	task test_straps;
		@(negedge clk_i);
		fit = ~FIT;
		size = 3'h2;
		amps = 13'h0543;
		ident = '{16'h0543, 16'h0002, 16'h1092, 16'h0016};
		repeat (4) @(negedge clk_i);
		test_ident();
		$display("strap test done");
	endtask : test_straps
	task test_reset;
		xf(1'b1, IDX_PASSWORD, 16'h1234);
		xf(1'b1, IDX_GROUP_SEL, 16'h00ff);
		xf(1'b1, IDX_THERMAL, 16'h0000);
		@(negedge clk_i);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		chk(pw, 16'h0000);
		chk(grp, 16'h0000);
		chk(te, 1'b1);
		chk(rsp_o.valid, 1'b0);
		repeat (4) @(negedge clk_i);
		xf(1'b0, IDX_SIZE_CODE, 16'h0);
		chk({r.valid, r.error, r.rdata}, {2'b10, ident[1]});
		$display("reset test done");
	endtask : test_reset
	task conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 2000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		test_password();
		test_ident();
		test_settings();
		test_unmapped();
		test_straps();
		test_reset();
		conclude();
	end
endmodule : tb_top
